// >>> design/ext_irq_prio_consts.vh
// Constants for the external interrupt priority front end.
// Assumes a 32-bit AHB-Lite register port and byte addresses in the low 8 bits.
`ifndef EXT_IRQ_PRIO_CONSTS_VH
`define EXT_IRQ_PRIO_CONSTS_VH

// Register byte offsets
`define IPC_OFF_PRIO_FIRST  8'h00
`define IPC_OFF_PRIO_LAST   8'h2C
`define IPC_OFF_REQ_EN      8'h30
`define IPC_OFF_SENSE       8'h34
`define IPC_OFF_NMI_EDGE    8'h38
`define IPC_OFF_STATUS      8'h3C
`define IPC_OFF_CLEAR       8'h40
`define IPC_OFF_INT_EN      8'h44

// Priority register layout
`define IPC_PRIO_RST        8'h77
`define IPC_PRIO_MASK       8'h77
`define IPC_PRIO_LO         2:0
`define IPC_PRIO_HI         6:4

// Field widths and masks
`define IPC_REQ_EN_MASK     6'h3F
`define IPC_REQ_EN_RST      6'h00
`define IPC_SENSE_RST       12'h000
`define IPC_STAT_RST        7'h00
`define IPC_NMI_BIT         6

// Sense codes
`define IPC_SENSE_LOW       2'h0
`define IPC_SENSE_FALL      2'h1
`define IPC_SENSE_RISE      2'h2
`define IPC_SENSE_BOTH      2'h3

// Levels and source codes toward the core
`define IPC_LVL_NMI         4'h8
`define IPC_SRC_NMI         3'h7
`define IPC_HTRANS_NONSEQ   1

`endif

// >>> design/ext_irq_priority_ctrl.v
// External interrupt priority front end: NMI plus six maskable requests,
// twelve priority registers, request enable, sense control, AHB-Lite slave.
// Assumes request pins come from outside the clock domain and the core
// acknowledges the request it takes with a one-cycle pulse.
//
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_prio_consts.vh"

module ext_irq_priority_ctrl #(
  parameter NUM_REQ  = 6,
  parameter NUM_PRIO = 12
) (
  input  wire        i_clk,
  input  wire        i_rstn,
  input  wire        i_hsel,
  input  wire [31:0] i_haddr,
  input  wire [1:0]  i_htrans,
  input  wire        i_hwrite,
  input  wire [2:0]  i_hsize,
  input  wire [31:0] i_hwdata,
  input  wire        i_hready,
  output wire        o_hreadyout,
  output wire [31:0] o_hrdata,
  output wire        o_hresp,
  input  wire        i_nmi_pin,
  input  wire [5:0]  i_maskable_ext_request_pins,
  input  wire        i_ack,
  input  wire [2:0]  i_ack_src,
  output wire        o_req_valid,
  output wire [2:0]  o_req_src,
  output wire [3:0]  o_req_level,
  output wire        o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  reg  [7:0]          priority_level_register_ff [0:NUM_PRIO-1];
  reg  [NUM_REQ-1:0]  request_enable_bits_ff;
  reg  [2*NUM_REQ-1:0] sense_ff;
  reg                 nmi_rise_sel_ff;
  reg  [NUM_REQ:0]    status_ff;
  reg  [NUM_REQ:0]    int_en_ff;

  wire [NUM_REQ:0]    pin_sync;

  reg                 wr_pend_ff;
  reg                 rd_pend_ff;
  reg  [7:0]          addr_ff;
  reg                 hreadyout_ff;
  reg  [31:0]         hrdata_ff;
  reg                 hresp_ff;

  reg                 req_valid_ff;
  reg  [2:0]          req_src_ff;
  reg  [3:0]          req_level_ff;
  reg                 irq_ff;

  wire                addr_phase;
  wire                wr_now;
  wire                prio_hit;
  wire [3:0]          prio_idx;
  wire [NUM_REQ:0]    detect;
  wire [NUM_REQ:0]    sw_clear;
  wire [NUM_REQ:0]    ack_clear;
  wire [NUM_REQ:0]    nxt_status;
  wire [2:0]          src_level [0:NUM_REQ-1];
  wire [1:0]          nmi_mode;

  reg  [31:0]         nxt_hrdata;
  reg                 nxt_req_valid;
  reg  [2:0]          nxt_req_src;
  reg  [3:0]          nxt_req_level;
  reg  [NUM_REQ:0]    ack_mask;

  integer             i;
  integer             j;
  genvar              g;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes zero wait, reads one wait state

  assign addr_phase = i_hsel & i_hready & i_htrans[`IPC_HTRANS_NONSEQ];
  assign wr_now     = wr_pend_ff;
  assign prio_hit   = (addr_ff <= `IPC_OFF_PRIO_LAST);
  assign prio_idx   = addr_ff[5:2];

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_pend_ff   <= 1'b0;
      rd_pend_ff   <= 1'b0;
      addr_ff      <= 8'h00;
      hreadyout_ff <= 1'b1;
      hrdata_ff    <= 32'h00000000;
      hresp_ff     <= 1'b0;
    end else begin
      wr_pend_ff <= addr_phase & i_hwrite;
      rd_pend_ff <= addr_phase & ~i_hwrite;
      if (addr_phase) begin
        addr_ff <= i_haddr[7:0];
      end
      if (addr_phase & ~i_hwrite) begin
        hreadyout_ff <= 1'b0;
      end else if (rd_pend_ff) begin
        hreadyout_ff <= 1'b1;
        hrdata_ff    <= nxt_hrdata;
      end
    end
  end

  // Read mux; unmapped and write-only addresses read zero
  always @* begin
    nxt_hrdata = 32'h00000000;
    if (prio_hit) begin
      nxt_hrdata[7:0] = priority_level_register_ff[prio_idx] & `IPC_PRIO_MASK;
    end else begin
      case (addr_ff)
        `IPC_OFF_REQ_EN:   nxt_hrdata[NUM_REQ-1:0]   = request_enable_bits_ff;
        `IPC_OFF_SENSE:    nxt_hrdata[2*NUM_REQ-1:0] = sense_ff;
        `IPC_OFF_NMI_EDGE: nxt_hrdata[0]             = nmi_rise_sel_ff;
        `IPC_OFF_STATUS:   nxt_hrdata[NUM_REQ:0]     = status_ff;
        `IPC_OFF_INT_EN:   nxt_hrdata[NUM_REQ:0]     = int_en_ff;
        default:           nxt_hrdata                = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (i = 0; i < NUM_PRIO; i = i + 1) begin
        priority_level_register_ff[i] <= `IPC_PRIO_RST;
      end
      request_enable_bits_ff <= `IPC_REQ_EN_RST;
      sense_ff               <= `IPC_SENSE_RST;
      nmi_rise_sel_ff        <= 1'b0;
      int_en_ff              <= `IPC_STAT_RST;
    end else if (wr_now) begin
      if (prio_hit) begin
        priority_level_register_ff[prio_idx] <= i_hwdata[7:0] & `IPC_PRIO_MASK;
      end else begin
        case (addr_ff)
          `IPC_OFF_REQ_EN: begin
            // Upper reserved bits are expected written as zero and not stored
            request_enable_bits_ff <= i_hwdata[NUM_REQ-1:0];
          end
          `IPC_OFF_SENSE: begin
            sense_ff <= i_hwdata[2*NUM_REQ-1:0];
          end
          `IPC_OFF_NMI_EDGE: begin
            nmi_rise_sel_ff <= i_hwdata[0];
          end
          `IPC_OFF_INT_EN: begin
            int_en_ff <= i_hwdata[NUM_REQ:0];
          end
          default: begin
            int_en_ff <= int_en_ff;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; pins idle high so reset to one

  sync_2ff #(
    .WIDTH     (NUM_REQ + 1),
    .RESET_VAL (1'b1)
  ) i_sync_2ff (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_async ({i_nmi_pin, i_maskable_ext_request_pins}),
    .o_sync  (pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Detection per maskable request

  generate
    for (g = 0; g < NUM_REQ; g = g + 1) begin : g_det
      pin_sense_detect #(
        .IDLE_LEVEL (1'b1)
      ) i_pin_sense_detect (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_level (pin_sync[g]),
        .i_mode  (sense_ff[2*g+1:2*g]),
        .o_hit   (detect[g])
      );
      // Source g takes the low field of register g/2 for even g, else high
      if (g % 2 == 0) begin : g_lo
        assign src_level[g] = priority_level_register_ff[g/2][`IPC_PRIO_LO];
      end else begin : g_hi
        assign src_level[g] = priority_level_register_ff[g/2][`IPC_PRIO_HI];
      end
    end
  endgenerate

  // NMI uses only the two single-edge codes of the shared decoder
  assign nmi_mode = nmi_rise_sel_ff ? `IPC_SENSE_RISE : `IPC_SENSE_FALL;

  pin_sense_detect #(
    .IDLE_LEVEL (1'b1)
  ) i_nmi_sense_detect (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_level (pin_sync[NUM_REQ]),
    .i_mode  (nmi_mode),
    .o_hit   (detect[NUM_REQ])
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status: detection wins over any clear in the same cycle

  assign sw_clear = (wr_now && addr_ff == `IPC_OFF_CLEAR) ?
                    i_hwdata[NUM_REQ:0] : {(NUM_REQ+1){1'b0}};

  always @* begin
    ack_mask = {(NUM_REQ+1){1'b0}};
    if (i_ack) begin
      if (i_ack_src == `IPC_SRC_NMI) begin
        ack_mask[NUM_REQ] = 1'b1;
      end else if (i_ack_src < NUM_REQ) begin
        ack_mask[i_ack_src] = 1'b1;
      end
    end
  end

  assign ack_clear  = ack_mask;
  assign nxt_status = (status_ff & ~(sw_clear | ack_clear)) | detect;

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      status_ff <= `IPC_STAT_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbiter: NMI first, then highest level, ties to lowest source number

  always @* begin
    nxt_req_valid = 1'b0;
    nxt_req_src   = 3'h0;
    nxt_req_level = 4'h0;
    for (j = NUM_REQ - 1; j >= 0; j = j - 1) begin
      if (status_ff[j] && request_enable_bits_ff[j] &&
          (!nxt_req_valid || {1'b0, src_level[j]} >= nxt_req_level)) begin
        nxt_req_valid = 1'b1;
        nxt_req_src   = j[2:0];
        nxt_req_level = {1'b0, src_level[j]};
      end
    end
    if (status_ff[NUM_REQ]) begin
      nxt_req_valid = 1'b1;
      nxt_req_src   = `IPC_SRC_NMI;
      nxt_req_level = `IPC_LVL_NMI;
    end
  end

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      req_valid_ff <= 1'b0;
      req_src_ff   <= 3'h0;
      req_level_ff <= 4'h0;
      irq_ff       <= 1'b0;
    end else begin
      req_valid_ff <= nxt_req_valid;
      req_src_ff   <= nxt_req_src;
      req_level_ff <= nxt_req_level;
      irq_ff       <= |(nxt_status & int_en_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_hreadyout = hreadyout_ff;
  assign o_hrdata    = hrdata_ff;
  assign o_hresp     = hresp_ff;
  assign o_req_valid = req_valid_ff;
  assign o_req_src   = req_src_ff;
  assign o_req_level = req_level_ff;
  assign o_irq       = irq_ff;

endmodule // ext_irq_priority_ctrl

////////////////////////////////////////////////////////////////////////////
// Sense decoder for one synchronised pin; the edge flop resets to the
// idle level so that no false edge follows reset

module pin_sense_detect #(
  parameter IDLE_LEVEL = 1'b1
) (
  input  wire       i_clk,
  input  wire       i_rstn,
  input  wire       i_level,
  input  wire [1:0] i_mode,
  output wire       o_hit
);

  reg               prev_ff;
  reg               hit;
  wire              fall;
  wire              rise;

  assign fall = prev_ff & ~i_level;
  assign rise = ~prev_ff & i_level;

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_ff <= IDLE_LEVEL;
    end else begin
      prev_ff <= i_level;
    end
  end

  always @* begin
    case (i_mode)
      `IPC_SENSE_LOW:  hit = ~i_level;
      `IPC_SENSE_FALL: hit = fall;
      `IPC_SENSE_RISE: hit = rise;
      `IPC_SENSE_BOTH: hit = fall | rise;
      default:         hit = 1'b0;
    endcase
  end

  assign o_hit = hit;

endmodule // pin_sense_detect

////////////////////////////////////////////////////////////////////////////
// Two-flop synchroniser for pins from outside the clock domain; only the
// second stage is read, the first may be metastable

module sync_2ff #(
  parameter WIDTH     = 1,
  parameter RESET_VAL = 1'b1
) (
  input  wire             i_clk,
  input  wire             i_rstn,
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  reg  [WIDTH-1:0]  meta_ff;
  reg  [WIDTH-1:0]  sync_ff;

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_ff <= {WIDTH{RESET_VAL}};
      sync_ff <= {WIDTH{RESET_VAL}};
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule // sync_2ff

`default_nettype wire

// >>> testbench/irq_prio_checker.sv
// Checker bound to the priority controller top.
// Assumes one read wait state, none for writes.
`timescale 1ns/1ps
`default_nettype none
module irq_prio_checker (
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic        o_hreadyout,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hresp,
  input wire logic        o_req_valid,
  input wire logic [2:0]  o_req_src,
  input wire logic [3:0]  o_req_level,
  input wire logic        i_ack
);
  logic rd, wr;
  assign rd = i_hsel & i_hready & i_htrans[1] & ~i_hwrite;
  assign wr = i_hsel & i_hready & i_htrans[1] & i_hwrite;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////
  chk_prio_rsvd: assert property (
    rd && i_haddr[7:0] <= 8'h2C |-> ##2 (o_hrdata & 32'hFFFFFF88) == 0) else $error("rsvd");
  chk_en_upper: assert property (
    rd && i_haddr[7:0] == 8'h30 |-> ##2 o_hrdata[31:6] == 0) else $error("en upper");
  chk_nmi_top: assert property (
    o_req_valid && o_req_src == 3'h7 |-> o_req_level == 4'h8) else $error("nmi lvl");
  chk_lvl_range: assert property (
    o_req_valid && o_req_src != 3'h7 |-> o_req_src <= 5 && o_req_level <= 7) else $error("lvl");
  chk_nmi_holds: assert property (
    o_req_valid && o_req_src == 3'h7 && !i_ack && !$past(i_ack) && !wr && !$past(wr)
    && !$past(wr, 2) |=> o_req_valid && o_req_src == 3'h7) else $error("nmi drop");
  chk_read_wait: assert property (rd |=> !o_hreadyout ##1 o_hreadyout) else $error("rd wait");
  chk_write_fast: assert property (wr |=> o_hreadyout) else $error("wr wait");
  chk_wait_once: assert property (!o_hreadyout |=> o_hreadyout) else $error("long wait");
  chk_resp_okay: assert property (o_hresp == 1'b0) else $error("resp not okay");
  cover property (rd);
  cover property (o_req_valid && o_req_src == 3'h7);
  cover property (o_req_valid && o_req_src != 3'h7);
endmodule // irq_prio_checker
bind ext_irq_priority_ctrl irq_prio_checker i_irq_prio_checker (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata),
  .o_hresp(o_hresp),
  .o_req_valid(o_req_valid), .o_req_src(o_req_src), .o_req_level(o_req_level), .i_ack(i_ack));
`default_nettype wire

// >>> testbench/core_model.sv
// Core model: acks the pending request after i_dly cycles.
// Assumes registered request outputs.
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_valid,
  input  wire logic [2:0] i_src,
  input  wire logic [3:0] i_dly,
  output var  logic       o_ack,
  output var  logic [2:0] o_ack_src
);
  logic [3:0] cnt_ff;
  // Count restarts after an ack so a stale request is not taken twice unless i_dly is zero
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_ff    <= 4'h0;
      o_ack     <= 1'b0;
      o_ack_src <= 3'h0;
    end else begin
      o_ack     <= i_valid && !o_ack && cnt_ff == i_dly;
      o_ack_src <= i_src;
      cnt_ff    <= (!i_valid || o_ack || cnt_ff == i_dly) ? 4'h0 : cnt_ff + 4'h1;
    end
  end
endmodule // core_model
`default_nettype wire

// >>> testbench/tb.sv
// Testbench: registers over AHB-Lite, request pins, core model.
// Assumes one read wait state and registered request outputs.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        i_clk, i_rstn, hsel, hwrite, nmi, hrdy, valid, ack, irq;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [5:0]  pins;
  logic [3:0]  dly, lvl;
  logic [2:0]  src, asrc;
  logic [19:0] cfg [3] = '{20'h25025, 20'h16161, 20'h33033};
  int          bad_count, cmp_count, cyc, t, i;
  ext_irq_priority_ctrl i_ext_irq_priority_ctrl (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy), .o_hrdata(hrdata), .o_hresp(),
    .i_nmi_pin(nmi), .i_maskable_ext_request_pins(pins), .i_ack(ack), .i_ack_src(asrc),
    .o_req_valid(valid), .o_req_src(src), .o_req_level(lvl), .o_irq(irq));
  core_model i_core_model (.i_clk(i_clk), .i_rstn(i_rstn), .i_valid(valid), .i_src(src),
    .i_dly(dly), .o_ack(ack), .o_ack_src(asrc));
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    htrans <= 2'h2;
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge i_clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(n, rd, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wait_for(input bit a);
    for (int k = 0; k < 40 && (a ? ack : valid) !== 1'b1; k++) @(posedge i_clk);
    chk(a ? "ack_wait" : "req_wait", a ? ack : valid, 1);
  endtask
  task automatic done;
    t++;
    $display("test %0d done", t);
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      report_and_stop;
    end
  end
  initial begin
    {i_rstn, hsel, htrans, hwrite, haddr, hwdata} = '0;
    {nmi, pins, dly} = {7'h7F, 4'h8};
    tick(3);
    i_rstn <= 1'b1;
    for (i = 0; i < 12; i++) begin
      rc("prio_rst", 8'(4 * i), 32'h77);
      xfer(8'(4 * i), 1'b1, (i * 17) | 32'h88);
      rc("prio_rw", 8'(4 * i), (i * 17) & 32'h77);
    end
    rc("en_rst", 8'h30, 32'h0);
    xfer(8'h30, 1'b1, 32'h3F);
    rc("en_rw", 8'h30, 32'h3F);
    xfer(8'h48, 1'b1, 32'hFFFFFFFF);
    rc("unmapped", 8'h48, 32'h0);
    xfer(8'h30, 1'b1, 32'h0);
    done;
    for (i = 0; i < 4; i++) begin
      xfer(8'h34, 1'b1, i);
      xfer(8'h40, 1'b1, 32'h7F);
      pins <= 6'h3E;
      tick(6);
      rc("sense_fall", 8'h3C, i != 2);
      xfer(8'h40, 1'b1, 32'h1);
      rc("sense_low", 8'h3C, i == 0);
      pins <= 6'h3F;
      tick(6);
      rc("sense_rise", 8'h3C, i != 1);
    end
    done;
    xfer(8'h34, 1'b1, 32'h555);
    xfer(8'h40, 1'b1, 32'h7F);
    pins <= 6'h00;
    tick(8);
    chk("masked", valid, 0);
    chk("irq_off", irq, 0);
    xfer(8'h44, 1'b1, 32'h3F);
    tick(3);
    chk("irq_on", irq, 1);
    xfer(8'h40, 1'b1, 32'h3F);
    tick(3);
    chk("irq_clr", irq, 0);
    xfer(8'h44, 1'b1, 32'h0);
    pins <= 6'h3F;
    tick(8);
    done;
    xfer(8'h30, 1'b1, 32'h3);
    for (i = 0; i < 3; i++) begin
      xfer(8'h00, 1'b1, cfg[i][7:0]);
      pins <= 6'h3C;
      wait_for(0);
      chk("src1", src, cfg[i][11:8]);
      chk("lvl1", lvl, cfg[i][15:12]);
      wait_for(1);
      tick(3);
      chk("src2", src, !cfg[i][8]);
      chk("lvl2", lvl, cfg[i][19:16]);
      wait_for(1);
      tick(3);
      chk("idle", valid, 0);
      pins <= 6'h3F;
      tick(8);
    end
    done;
    xfer(8'h30, 1'b1, 32'h0);
    dly <= 4'h1;
    for (i = 0; i < 2; i++) begin
      xfer(8'h38, 1'b1, i);
      nmi <= i[0];
      wait_for(0);
      chk("nmi_src", src, 7);
      chk("nmi_lvl", lvl, 8);
      tick(6);
    end
    done;
    report_and_stop;
  end
endmodule // tb
`default_nettype wire
